// >>> inc/msh_pkg.sv
// shared constants, types and states of the meter serial host port
package msh_pkg;
    // frame identifiers and markers
    localparam logic [7:0] ID_WRITE = 8'hA8;
    localparam logic [7:0] ID_READ = 8'h58;
    localparam logic [7:0] PKT_ADDR = 8'hAA;
    localparam logic [7:0] PKT_HEAD = 8'h55;
    localparam logic [7:0] SOFT_RST_BYTE = 8'hFF;
    localparam logic [2:0] SOFT_RST_LAST = 3'h5;
    // index of the last clock pulse in a spi frame
    localparam logic [5:0] SPI_LAST_BIT = 6'h2F;
    // uart response lengths in bytes, index of the transmit stop bit
    localparam logic [5:0] REG_RESP_LEN = 6'h04;
    localparam logic [5:0] PKT_LEN = 6'h23;
    localparam logic [3:0] TX_STOP_IDX = 4'h9;
    // timing, times in ns
    localparam longint CLK_MHZ = 200;
    localparam longint BIT_NS = 208000;
    localparam longint HALF_BIT_NS = 104000;
    localparam longint STOP_NS = 208000 + 104000;
    localparam longint TIMEOUT_NS = 18500000;
    localparam longint BREAK_NS = 6650000;
    localparam int BIT_CYC = int'(BIT_NS * CLK_MHZ / 1000);
    localparam int HALF_CYC = int'(HALF_BIT_NS * CLK_MHZ / 1000);
    localparam int STOP_CYC = int'(STOP_NS * CLK_MHZ / 1000);
    localparam int TIMEOUT_CYC = int'((TIMEOUT_NS * CLK_MHZ + 999) / 1000);
    localparam int BREAK_CYC = int'((BREAK_NS * CLK_MHZ + 999) / 1000);
    localparam int CNT_W = 23;
    // buffering
    localparam int WR_FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        FR_ID, FR_ADDR, FR_D0, FR_D1, FR_D2, FR_CSUM, FR_PUSH, FR_RESP
    } msh_frame_e;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} msh_rx_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [23:0] data;
    } msh_wr_s;

    typedef struct packed {
        logic [23:0] fast_rms;
        logic [23:0] rms;
        logic [23:0] voltage_rms;
        logic [23:0] active_power_value;
        logic [23:0] energy_pulse_count;
        logic [9:0] internal_temperature_value;
        logic [9:0] external_temperature_value;
    } msh_meas_s;
endpackage

// >>> test/msh_host.sv
// host model: spi master and uart peer of the port
`timescale 1ns/100ps
module msh_host (
    // pins
    output logic sclk_out,
    output logic rx_out,
    input wire logic sdo_in,
    input wire logic tx_in
);
    initial begin
        sclk_out = 1'b0;
        rx_out = 1'b1;
    end
    // launch on rise, sample on fall
    task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            sclk_out = 1'b1;
            rx_out = b[i];
            #62.5;
            sclk_out = 1'b0;
            r[i] = sdo_in;
            #62.5;
        end
        // data line idles high so no false break
        rx_out = 1'b1;
    endtask
    // start, eight bits lsb first, 1.5 stop
    task automatic uart_send(input logic [7:0] b);
        rx_out = 1'b0;
        #200;
        for (int i = 0; i < 8; i++) begin
            rx_out = b[i];
            #200;
        end
        rx_out = 1'b1;
        #300;
    endtask
    // bounded wait for start, then mid-bit sampling
    task automatic uart_recv(output logic [7:0] b, output logic ok);
        int n = 0;
        while (tx_in !== 1'b0 && n < 4000) begin
            #1;
            n++;
        end
        #100;
        ok = n < 4000 && tx_in === 1'b0;
        for (int i = 0; i < 8; i++) begin
            #200;
            b[i] = tx_in;
        end
        #200;
        ok = ok && tx_in === 1'b1;
    endtask
endmodule

// >>> test/test_meter_serial_host_port.sv
// bench: spi and uart frames against the host port
`timescale 1ns/100ps
module test_meter_serial_host_port;
    import msh_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sel = 1'b1, wr_ready = 1'b0, ok;
    logic sclk, rx, sdo, oe, tx, rd_req, wr_valid;
    logic [7:0] rd_addr, r0, r1, r2, r3, rb [35];
    logic [23:0] rd_data;
    msh_wr_s wr;
    msh_meas_s meas = {24'h12_3456, 24'h78_9abc, 24'hde_f012, 24'h34_5678,
        24'h9a_bcde, 10'h2a5, 10'h15a};
    int bad_count = 0, checks = 0;
    // register file stand-in: value follows the address, one cycle late
    always @(posedge clk) if (rd_req) rd_data <= {rd_addr, 8'h3c, ~rd_addr};
    initial forever #2.5 clk = ~clk;
    msh_port #(.BIT_CYC_P(40), .HALF_CYC_P(20), .STOP_CYC_P(60),
        .TIMEOUT_CYC_P(2000), .BREAK_CYC_P(600)) msh_port_inst (
        .sys_clk_in(clk), .rst_in(rst), .sel_spi_in(sel),
        .spi_sclk_in(sclk), .serial_rx_in(rx), .spi_sdo_out(sdo),
        .spi_sdo_oe_out(oe), .uart_tx_out(tx), .rd_req_out(rd_req),
        .rd_addr_out(rd_addr), .rd_data_in(rd_data), .meas_in(meas),
        .wr_out(wr), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready));
    msh_host msh_host_inst (.sclk_out(sclk), .rx_out(rx), .sdo_in(sdo),
        .tx_in(tx));
    task automatic chk(input string s, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic logic [7:0] sum(input logic [7:0] i, a,
                                       input logic [23:0] d);
        return 8'(~(i + a + d[23:16] + d[15:8] + d[7:0]));
    endfunction
    task automatic spi_frame(input logic [7:0] i, a, input logic [23:0] d);
        msh_host_inst.spi_byte(i, r0);
        msh_host_inst.spi_byte(a, r0);
        msh_host_inst.spi_byte(d[23:16], r0);
        msh_host_inst.spi_byte(d[15:8], r1);
        msh_host_inst.spi_byte(d[7:0], r2);
        msh_host_inst.spi_byte(i == ID_READ ? 8'h00 : sum(i, a, d), r3);
    endtask
    task automatic uart_wr(input logic [7:0] a, input logic [23:0] d,
                           input logic [7:0] cs);
        msh_host_inst.uart_send(ID_WRITE);
        msh_host_inst.uart_send(a);
        for (int k = 0; k < 3; k++) msh_host_inst.uart_send(d[8*k+:8]);
        msh_host_inst.uart_send(cs);
    endtask
    // listen while the last command byte goes out
    task automatic uart_rd(input logic [7:0] a, input int n);
        msh_host_inst.uart_send(ID_READ);
        fork
            msh_host_inst.uart_send(a);
            for (int i = 0; i < n; i++) begin
                msh_host_inst.uart_recv(rb[i], ok);
                chk("uok", ok, 1'b1);
                if (ok !== 1'b1) report_and_stop();
            end
        join
        #300;
    endtask
    // bounded wait for the fifo head, then one pop
    task automatic pop(input logic [31:0] exp);
        int n = 0;
        while (wr_valid !== 1'b1 && n < 9000) begin
            @(posedge clk) #1;
            n++;
        end
        chk("wrv", wr_valid, 1'b1);
        chk("wr", wr, exp);
        if (n == 9000) report_and_stop();
        @(posedge clk) #1 wr_ready = 1'b1;
        @(posedge clk) #1 wr_ready = 1'b0;
    endtask
    initial begin
        logic [7:0] e [35], s;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        // four fill the fifo, the fifth stalls
        for (int i = 0; i < 5; i++) spi_frame(ID_WRITE, 8'(i), 24'(i));
        for (int i = 0; i < 5; i++) pop({8'(i), 24'(i)});
        spi_frame(ID_READ, 8'h21, 24'h0);
        chk("sdata", {r0, r1, r2}, {8'h21, 8'h3c, 8'hde});
        chk("scsum", r3, sum(ID_READ, 8'h21, {8'h21, 8'h3c, 8'hde}));
        #100 chk("oe", oe, 1'b0);
        // stray bytes, then six all-ones bytes realign
        msh_host_inst.spi_byte(ID_WRITE, r0);
        msh_host_inst.spi_byte(8'h12, r0);
        repeat (6) msh_host_inst.spi_byte(SOFT_RST_BYTE, r0);
        spi_frame(ID_READ, 8'h22, 24'h0);
        chk("srst", {r0, r1, r2}, {8'h22, 8'h3c, 8'hdd});
        @(posedge clk) #1 sel = 1'b0;
        #1000;
        // uart read, wait for the whole answer
        uart_rd(8'h33, 4);
        chk("udata", {rb[2], rb[1], rb[0]}, {8'h33, 8'h3c, 8'hcc});
        chk("ucsum", rb[3], sum(ID_READ, 8'h33, 24'h333c_cc));
        // packet: header, low bytes first, zero pads
        e = '{default: 8'h00};
        e[0] = PKT_HEAD;
        {e[3], e[2], e[1]} = meas.fast_rms;
        {e[6], e[5], e[4]} = meas.rms;
        {e[12], e[11], e[10]} = meas.voltage_rms;
        {e[18], e[17], e[16]} = meas.active_power_value;
        {e[24], e[23], e[22]} = meas.energy_pulse_count;
        {e[29], e[28]} = 16'(meas.internal_temperature_value);
        {e[32], e[31]} = 16'(meas.external_temperature_value);
        s = ID_READ;
        for (int k = 0; k < 34; k++) s += e[k];
        e[34] = ~s;
        uart_rd(PKT_ADDR, 35);
        for (int k = 0; k < 35; k++) chk("pkt", rb[k], e[k]);
        uart_wr(8'h40, 24'h0102, 8'h00);
        // partial frame abandoned after a long gap
        msh_host_inst.uart_send(ID_WRITE);
        #12000;
        uart_wr(8'h41, 24'h0304, sum(ID_WRITE, 8'h41, 24'h0304));
        pop({8'h41, 24'h0304});
        #100 chk("empty", wr_valid, 1'b0);
        report_and_stop();
    end
endmodule

// >>> verilog/msh_port.sv
// meter serial host port: spi/uart frame decoder, responder, write fifo
`timescale 1ns/100ps

module msh_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = count != (AW+1)'(DEPTH);
    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Function
// R01 - spi write bits captured on falling edges
// R02 - write frame: 0xA8, address, data, checksum
// R03 - read frame: 0x58 then address
// R04 - sdo launched on rising, held while high
// R05 - readout starts at rising edge after address
// R06 - sdo released at last falling edge
// R07 - after read, wait for new identifier
// R08 - six 0xFF bytes reset spi only
// R09 - uart 4800 baud, 8n, 1.5 stop
// R10 - start 208us, stop 312us high
// R11 - uart transmits only answering host commands
// R12 - uart data three bytes, low first
// R13 - write checksum inverted sum, checked
// R14 - read checksum inverted sum with 0x58
// R15 - address 0xAA returns 35-byte packet
// R16 - packet checksum covers 0x58, header, data
// R17 - uart gap over 18.5ms abandons frame
// R18 - bad identifier or checksum frame discarded
// R19 - rx low over 6.65ms resets uart
// R20 - spi mode 1, sample on falling
// R21 - every spi frame is 48 pulses
// R22 - spi data msb byte and bit first
// R23 - host waits for complete read response
module msh_port
    import msh_pkg::*;
#(
    parameter int BIT_CYC_P = BIT_CYC,
    parameter int HALF_CYC_P = HALF_CYC,
    parameter int STOP_CYC_P = STOP_CYC,
    parameter int TIMEOUT_CYC_P = TIMEOUT_CYC,
    parameter int BREAK_CYC_P = BREAK_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // pins
    input wire logic sel_spi_in,
    input wire logic spi_sclk_in,
    input wire logic serial_rx_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    output logic uart_tx_out,
    // register read side
    output logic rd_req_out,
    output logic [7:0] rd_addr_out,
    input wire logic [23:0] rd_data_in,
    input wire msh_pkg::msh_meas_s meas_in,
    // register write side
    output msh_pkg::msh_wr_s wr_out,
    output logic wr_valid_out,
    input wire logic wr_ready_in
);
    import msh_pkg::*;

    logic sclk_s1, sclk_s2, sclk_s3, rx_s1, rx_s2, sel_s1, sel_s2;
    logic sclk_rise, sclk_fall, spi_mode;
    logic [7:0] spi_sh;
    logic [5:0] frame_bit;
    logic [2:0] ff_cnt;
    logic spi_byte_evt, spi_frame_end, spi_soft;
    logic [7:0] spi_byte;
    logic [31:0] spi_tx;
    logic spi_tx_en;
    msh_rx_e rx_state;
    logic [CNT_W-1:0] rx_cnt, low_cnt, gap_cnt, tx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh, uart_byte;
    logic uart_byte_evt, uart_break, uart_timeout, uart_rst;
    logic tx_busy, tx_last, tx_done, tx_go;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    msh_frame_e state;
    logic byte_evt, fr_rst, is_pkt, resp_go, rd_load;
    logic [7:0] byte_val, addr, sum, resp_byte, spi_csum;
    logic [23:0] data, rd_word;
    logic [5:0] resp_idx, resp_len;
    msh_meas_s meas_q;
    logic fifo_in_ready;

    // pins cross into the clock domain
    always_ff @(posedge sys_clk_in) begin
        sclk_s1 <= spi_sclk_in;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        rx_s1 <= serial_rx_in;
        rx_s2 <= rx_s1;
        sel_s1 <= sel_spi_in;
        sel_s2 <= sel_s1;
    end

    // R20 mode 1 edges
    assign sclk_rise = sclk_s2 && !sclk_s3;
    assign sclk_fall = !sclk_s2 && sclk_s3;
    assign spi_mode = sel_s2;

    // R22 msb first
    assign spi_byte = {spi_sh[6:0], rx_s2};
    assign spi_byte_evt = spi_mode && sclk_fall && frame_bit[2:0] == 3'h7;
    // R21 48 pulses
    assign spi_frame_end = spi_mode && sclk_fall && frame_bit == SPI_LAST_BIT;
    // R08 six 0xFF
    assign spi_soft = spi_byte_evt && spi_byte == SOFT_RST_BYTE
        && ff_cnt == SOFT_RST_LAST;

    // R01 capture on falling
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || spi_soft) begin
            spi_sh <= '0;
            frame_bit <= '0;
        end else if (spi_mode && sclk_fall) begin
            spi_sh <= spi_byte;
            frame_bit <= spi_frame_end ? '0 : frame_bit + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || spi_soft) begin
            ff_cnt <= '0;
        end else if (spi_byte_evt) begin
            ff_cnt <= (spi_byte == SOFT_RST_BYTE) ? ff_cnt + 1'b1 : '0;
        end
    end

    // R14 checksum for spi readout
    assign spi_csum = ~(sum + rd_data_in[23:16] + rd_data_in[15:8]
        + rd_data_in[7:0]);

    // R04 launch on rising
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || spi_soft) begin
            spi_tx <= '0;
            spi_tx_en <= 1'b0;
            spi_sdo_out <= 1'b0;
            spi_sdo_oe_out <= 1'b0;
        end else if (spi_mode) begin
            if (rd_load) begin
                spi_tx <= {rd_data_in, spi_csum};
                spi_tx_en <= 1'b1;
            end else if (spi_frame_end) begin
                // R06 release at last falling
                spi_tx_en <= 1'b0;
                spi_sdo_oe_out <= 1'b0;
            end else if (sclk_rise && spi_tx_en) begin
                // R05 shift out
                spi_sdo_out <= spi_tx[31];
                spi_tx <= {spi_tx[30:0], 1'b0};
                spi_sdo_oe_out <= 1'b1;
            end
        end
    end

    // R19 break detect
    assign uart_break = rx_s2 && low_cnt == CNT_W'(BREAK_CYC_P + 1);
    assign uart_rst = rst_in || uart_break;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || rx_s2) begin
            low_cnt <= '0;
        end else if (low_cnt != CNT_W'(BREAK_CYC_P + 1)) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // R09 receive 8n with stop check
    always_ff @(posedge sys_clk_in) begin
        uart_byte_evt <= 1'b0;
        if (uart_rst || spi_mode) begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_sh <= '0;
            uart_byte <= '0;
        end else begin
            rx_cnt <= rx_cnt + 1'b1;
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= '0;
                    if (!rx_s2) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt == CNT_W'(HALF_CYC_P - 1)) begin
                        rx_cnt <= '0;
                        rx_bit <= '0;
                        rx_state <= rx_s2 ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt == CNT_W'(BIT_CYC_P - 1)) begin
                        rx_cnt <= '0;
                        rx_sh <= {rx_s2, rx_sh[7:1]};
                        rx_bit <= rx_bit + 1'b1;
                        if (rx_bit == 3'h7) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt == CNT_W'(BIT_CYC_P - 1)) begin
                        uart_byte_evt <= rx_s2;
                        uart_byte <= rx_sh;
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // R17 inter-byte timeout
    assign uart_timeout = gap_cnt == CNT_W'(TIMEOUT_CYC_P + 1);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || spi_mode || uart_byte_evt || state == FR_ID
                || state == FR_PUSH || state == FR_RESP || uart_timeout) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // R10 start 208us, stop 312us
    assign tx_last = (tx_bit == TX_STOP_IDX)
        ? tx_cnt == CNT_W'(STOP_CYC_P - 1)
        : tx_cnt == CNT_W'(BIT_CYC_P - 1);
    assign tx_done = tx_busy && tx_last && tx_bit == TX_STOP_IDX;
    assign tx_go = resp_go && !tx_busy;

    always_ff @(posedge sys_clk_in) begin
        if (uart_rst) begin
            tx_busy <= 1'b0;
            tx_bit <= '0;
            tx_cnt <= '0;
            tx_sh <= '0;
            uart_tx_out <= 1'b1;
        end else if (!tx_busy) begin
            if (tx_go) begin
                tx_busy <= 1'b1;
                tx_bit <= '0;
                tx_cnt <= '0;
                tx_sh <= resp_byte;
                uart_tx_out <= 1'b0;
            end
        end else if (tx_last) begin
            tx_cnt <= '0;
            if (tx_bit == TX_STOP_IDX) begin
                tx_busy <= 1'b0;
            end else begin
                tx_bit <= tx_bit + 1'b1;
                uart_tx_out <= (tx_bit == 4'h8) ? 1'b1 : tx_sh[0];
                tx_sh <= {1'b0, tx_sh[7:1]};
            end
        end else begin
            tx_cnt <= tx_cnt + 1'b1;
        end
    end

    // R15 packet layout
    function automatic logic [7:0] pick(input logic [23:0] v,
                                        input logic [5:0] off);
        logic [1:0] k;
        k = off[1:0];
        return v[k*8 +: 8];
    endfunction

    always_comb begin
        resp_byte = 8'h00;
        if (resp_idx == resp_len - 1'b1) begin
            resp_byte = ~sum;
        end else if (!is_pkt) begin
            // R12 low byte first
            resp_byte = pick(rd_word, resp_idx);
        end else begin
            case (resp_idx)
                6'h00: resp_byte = PKT_HEAD;
                6'h01, 6'h02, 6'h03:
                    resp_byte = pick(meas_q.fast_rms, resp_idx - 6'h01);
                6'h04, 6'h05, 6'h06:
                    resp_byte = pick(meas_q.rms, resp_idx - 6'h04);
                6'h0A, 6'h0B, 6'h0C:
                    resp_byte = pick(meas_q.voltage_rms, resp_idx - 6'h0A);
                6'h10, 6'h11, 6'h12:
                    resp_byte = pick(meas_q.active_power_value,
                                     resp_idx - 6'h10);
                6'h16, 6'h17, 6'h18:
                    resp_byte = pick(meas_q.energy_pulse_count,
                                     resp_idx - 6'h16);
                6'h1C: resp_byte = meas_q.internal_temperature_value[7:0];
                6'h1D: resp_byte =
                    {6'h00, meas_q.internal_temperature_value[9:8]};
                6'h1F: resp_byte = meas_q.external_temperature_value[7:0];
                6'h20: resp_byte =
                    {6'h00, meas_q.external_temperature_value[9:8]};
                default: resp_byte = 8'h00;
            endcase
        end
    end

    assign byte_evt = spi_mode ? spi_byte_evt : uart_byte_evt;
    assign byte_val = spi_mode ? spi_byte : uart_byte;
    assign fr_rst = rst_in
        || (spi_mode ? spi_soft : uart_break || uart_timeout);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_load <= 1'b0;
            rd_word <= '0;
            meas_q <= '0;
        end else begin
            rd_load <= rd_req_out;
            if (rd_load) begin
                rd_word <= rd_data_in;
                meas_q <= meas_in;
            end
        end
    end

    // frame decoder and responder
    always_ff @(posedge sys_clk_in) begin
        rd_req_out <= 1'b0;
        if (fr_rst) begin
            state <= FR_ID;
            is_pkt <= 1'b0;
            addr <= '0;
            data <= '0;
            sum <= '0;
            resp_idx <= '0;
            resp_len <= REG_RESP_LEN;
            resp_go <= 1'b0;
        end else begin
            case (state)
                FR_ID: begin
                    // R02 R03 identifier
                    if (byte_evt && (byte_val == ID_WRITE
                            || byte_val == ID_READ)) begin
                        sum <= byte_val;
                        state <= FR_ADDR;
                    end
                end
                FR_ADDR: begin
                    if (byte_evt) begin
                        addr <= byte_val;
                        sum <= sum + byte_val;
                        state <= FR_D0;
                        if (sum == ID_READ) begin
                            state <= FR_RESP;
                            rd_req_out <= 1'b1;
                            resp_idx <= '0;
                            is_pkt <= !spi_mode && byte_val == PKT_ADDR;
                            resp_len <= (!spi_mode && byte_val == PKT_ADDR)
                                ? PKT_LEN : REG_RESP_LEN;
                            // R16 packet sum omits address
                            if (!spi_mode && byte_val == PKT_ADDR) begin
                                sum <= ID_READ;
                            end
                        end
                    end
                end
                FR_D0, FR_D1, FR_D2: begin
                    if (byte_evt) begin
                        // R22 spi high byte first, uart low first
                        data <= spi_mode ? {data[15:0], byte_val}
                                         : {byte_val, data[23:8]};
                        sum <= sum + byte_val;
                        state <= (state == FR_D0) ? FR_D1
                               : (state == FR_D1) ? FR_D2 : FR_CSUM;
                    end
                end
                FR_CSUM: begin
                    // R13 R18 checksum gate
                    if (byte_evt) begin
                        state <= (byte_val == ~sum) ? FR_PUSH : FR_ID;
                    end
                end
                FR_PUSH: begin
                    if (fifo_in_ready) begin
                        state <= FR_ID;
                    end
                end
                FR_RESP: begin
                    // R07 back to identifier wait
                    if (spi_mode) begin
                        if (spi_frame_end) begin
                            state <= FR_ID;
                        end
                    end else begin
                        // R11 answers only here
                        if (rd_load) begin
                            resp_go <= 1'b1;
                        end
                        if (tx_go) begin
                            resp_go <= 1'b0;
                            sum <= sum + resp_byte;
                        end
                        if (tx_done) begin
                            if (resp_idx == resp_len - 1'b1) begin
                                state <= FR_ID;
                            end else begin
                                resp_idx <= resp_idx + 1'b1;
                                resp_go <= 1'b1;
                            end
                        end
                    end
                end
                default: begin
                    state <= FR_ID;
                end
            endcase
            // R21 spi frame boundary
            if (spi_frame_end && state != FR_CSUM && state != FR_PUSH) begin
                state <= FR_ID;
            end
        end
    end

    assign rd_addr_out = addr;

    // stalls the decoder in FR_PUSH while full
    msh_fifo #(.WIDTH(32), .DEPTH(WR_FIFO_DEPTH)) u_wr_fifo (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_data_in({addr, data}),
        .in_valid_in(state == FR_PUSH),
        .in_ready_out(fifo_in_ready),
        .out_data_out(wr_out),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in)
    );

    sequence s_read_addr;
        state == FR_ADDR && byte_evt && sum == ID_READ;
    endsequence
    sequence s_load;
        rd_req_out ##1 rd_load;
    endsequence

    AST_READ_LOAD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        s_read_addr |=> s_load ##0 state == FR_RESP) // R05
        else $error("read address did not start readout");
    AST_SDO_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !sclk_rise && !spi_soft |=> $stable(spi_sdo_out)) // R04
        else $error("sdo changed without rising sclk");
    AST_SDO_RELEASE: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        spi_frame_end && state != FR_CSUM && state != FR_PUSH
            |=> !spi_sdo_oe_out && state == FR_ID) // R06
        else $error("sdo not released at frame end");
    AST_SOFT_RESET: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        spi_soft |=> frame_bit == 6'h00 && state == FR_ID
            && ff_cnt == 3'h0) // R08
        else $error("spi soft reset not applied");
    AST_TX_QUIET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        tx_busy |-> state == FR_RESP && !spi_mode) // R11
        else $error("uart sends outside a response");
    AST_TX_BIT_LEN: assert property (@(posedge sys_clk_in)
        disable iff (rst_in || uart_break)
        (tx_busy && $past(tx_busy) && $changed(tx_bit)) |->
            $past(tx_cnt) == CNT_W'(BIT_CYC_P - 1)) // R10
        else $error("uart bit length wrong");
    AST_BAD_CSUM: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state == FR_CSUM && byte_evt && byte_val != ~sum && !fr_rst)
            |=> state == FR_ID ##1 !wr_valid_out || $stable(wr_out)) // R18
        else $error("bad checksum frame not discarded");
    AST_GOOD_WR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state == FR_CSUM && byte_evt && byte_val == ~sum && !fr_rst)
            |=> state == FR_PUSH) // R13
        else $error("good write frame not queued");
    AST_TIMEOUT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (uart_timeout && !spi_mode) |=> state == FR_ID) // R17
        else $error("uart timeout did not abandon frame");
    AST_BREAK: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (uart_break && !spi_mode) |=> rx_state == RX_IDLE && !tx_busy
            && state == FR_ID) // R19
        else $error("uart break did not reset uart");
    AST_LAST_CSUM: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (tx_go && resp_idx == resp_len - 1'b1) |-> resp_byte == ~sum) // R14
        else $error("response checksum wrong");
endmodule
